// >>> include/dec_pkg.sv
package dec_pkg;
    typedef enum logic [4:0] {
        OP_NONE = 5'd0, OP_SUB_LONG = 5'd1, OP_SUB_MEM = 5'd2,
        OP_SUB_BORROW = 5'd3, OP_SUB_HIGH = 5'd4, OP_SUB_SHORT = 5'd5,
        OP_SUB_LOW_NSX = 5'd6, OP_SUB_TREG = 5'd7, OP_XOR_LONG = 5'd8,
        OP_CLR_LOAD_HIGH = 5'd9, OP_CLR_LOAD_HIGH_RND = 5'd10,
        OP_CLR_LOAD_LOW_NSX = 5'd11, OP_STORE_LOW = 5'd12,
        OP_AUX_ADD = 5'd13, OP_AUX_CMP = 5'd14, OP_AUX_LOAD_SHORT = 5'd15,
        OP_AUX_PTR = 5'd16, OP_PAGE_MEM = 5'd17, OP_PAGE_IMM = 5'd18,
        OP_AUX_LOAD_LONG = 5'd19, OP_AUX_SUB = 5'd20, OP_ADD_PROD = 5'd21,
        OP_TREG_ACC_PROD = 5'd22
    } op_t;
    localparam logic [7:0] BYTE_SUB_BORROW  = 8'h4f;
    localparam logic [7:0] BYTE_SUB_HIGH    = 8'h44;
    localparam logic [7:0] BYTE_SUB_SHORT   = 8'hcd;
    localparam logic [7:0] BYTE_SUB_LOW_NSX = 8'h45;
    localparam logic [7:0] BYTE_SUB_TREG    = 8'h46;
    localparam logic [7:0] BYTE_CLR_HIGH    = 8'h40;
    localparam logic [7:0] BYTE_CLR_HIGH_R  = 8'h7b;
    localparam logic [7:0] BYTE_CLR_LOW     = 8'h41;
    localparam logic [7:0] BYTE_AUX_ADD     = 8'h7e;
    localparam logic [7:0] BYTE_AUX_SUB     = 8'h7f;
    localparam logic [7:0] BYTE_PAGE_MEM    = 8'h52;
    localparam logic [7:0] BYTE_AUX_PTR     = 8'h55;
    localparam logic [7:0] BYTE_TREG_ACC    = 8'h3d;
    localparam logic [3:0] NIB_SUB_MEM      = 4'h1;
    localparam logic [3:0] NIB_LONG         = 4'hd;
    localparam logic [7:0] LOW_SUB_LONG     = 8'h03;
    localparam logic [7:0] LOW_XOR_LONG     = 8'h06;
    localparam logic [7:0] LOW_AUX_LONG     = 8'h00;
    localparam logic [4:0] TOP_STORE_LOW    = 5'h0c;
    localparam logic [4:0] TOP_AUX_SHORT    = 5'h18;
    localparam logic [6:0] TOP_PAGE_IMM     = 7'h64;
    localparam logic [13:0] TOP_AUX_CMP     = 14'h3394;
    localparam logic [15:0] WORD_ADD_PROD   = 16'hce15;
    localparam logic [3:0] AUX_PTR_TAG      = 4'h1;
endpackage

// >>> include/dec_if.sv
`timescale 1ns/1ps
// decoded fields travelling from the combinational decoder to the top
interface dec_if;
    dec_pkg::op_t op;
    logic         two_word;
    logic [3:0]   shift;
    logic         mode;
    logic [6:0]   addr;
    logic [2:0]   reg_sel;
    logic [8:0]   imm;
    logic [1:0]   cmp_mode;
    logic         valid;
    modport dec (output op, two_word, shift, mode, addr, reg_sel, imm,
                 cmp_mode, valid);
    modport top (input op, two_word, shift, mode, addr, reg_sel, imm,
                 cmp_mode, valid);
endinterface

// >>> logic/op_table.sv
`timescale 1ns/1ps
module op_table (
    input  wire logic [15:0] word,
    dec_if.dec               d
);
    always_comb begin
        d.op       = dec_pkg::OP_NONE;
        d.two_word = 1'b0;
        d.shift    = word[11:8];
        d.mode     = word[7];
        d.addr     = word[6:0];
        d.reg_sel  = word[10:8];
        d.imm      = {1'b0, word[7:0]};
        d.cmp_mode = word[1:0];
        if (word == dec_pkg::WORD_ADD_PROD) begin
            d.op = dec_pkg::OP_ADD_PROD;
        end else if (word[15:2] == dec_pkg::TOP_AUX_CMP) begin
            d.op = dec_pkg::OP_AUX_CMP;
        end else if (word[15:12] == dec_pkg::NIB_LONG
                     && word[7:0] == dec_pkg::LOW_SUB_LONG) begin
            d.op       = dec_pkg::OP_SUB_LONG;
            d.two_word = 1'b1;
        end else if (word[15:12] == dec_pkg::NIB_LONG
                     && word[7:0] == dec_pkg::LOW_XOR_LONG) begin
            d.op       = dec_pkg::OP_XOR_LONG;
            d.two_word = 1'b1;
        end else if (word[15:12] == dec_pkg::NIB_LONG && !word[11]
                     && word[7:0] == dec_pkg::LOW_AUX_LONG) begin
            d.op       = dec_pkg::OP_AUX_LOAD_LONG;
            d.two_word = 1'b1;
        end else if (word[15:12] == dec_pkg::NIB_SUB_MEM) begin
            d.op = dec_pkg::OP_SUB_MEM;
        end else if (word[15:11] == dec_pkg::TOP_STORE_LOW) begin
            d.op    = dec_pkg::OP_STORE_LOW;
            d.shift = {1'b0, word[10:8]};
        end else if (word[15:11] == dec_pkg::TOP_AUX_SHORT) begin
            d.op = dec_pkg::OP_AUX_LOAD_SHORT;
        end else if (word[15:9] == dec_pkg::TOP_PAGE_IMM) begin
            d.op  = dec_pkg::OP_PAGE_IMM;
            d.imm = word[8:0];
        end else if (word[15:8] == dec_pkg::BYTE_AUX_PTR
                     && word[6:3] == dec_pkg::AUX_PTR_TAG) begin
            d.op      = dec_pkg::OP_AUX_PTR;
            d.reg_sel = word[2:0];
        end else begin
            unique case (word[15:8])
                dec_pkg::BYTE_SUB_BORROW:
                    d.op = dec_pkg::OP_SUB_BORROW;
                dec_pkg::BYTE_SUB_HIGH:
                    d.op = dec_pkg::OP_SUB_HIGH;
                dec_pkg::BYTE_SUB_SHORT:
                    d.op = dec_pkg::OP_SUB_SHORT;
                dec_pkg::BYTE_SUB_LOW_NSX:
                    d.op = dec_pkg::OP_SUB_LOW_NSX;
                dec_pkg::BYTE_SUB_TREG:
                    d.op = dec_pkg::OP_SUB_TREG;
                dec_pkg::BYTE_CLR_HIGH:
                    d.op = dec_pkg::OP_CLR_LOAD_HIGH;
                dec_pkg::BYTE_CLR_HIGH_R:
                    d.op = dec_pkg::OP_CLR_LOAD_HIGH_RND;
                dec_pkg::BYTE_CLR_LOW:
                    d.op = dec_pkg::OP_CLR_LOAD_LOW_NSX;
                dec_pkg::BYTE_AUX_ADD:
                    d.op = dec_pkg::OP_AUX_ADD;
                dec_pkg::BYTE_AUX_SUB:
                    d.op = dec_pkg::OP_AUX_SUB;
                dec_pkg::BYTE_PAGE_MEM:
                    d.op = dec_pkg::OP_PAGE_MEM;
                dec_pkg::BYTE_TREG_ACC:
                    d.op = dec_pkg::OP_TREG_ACC_PROD;
                default:
                    d.op = dec_pkg::OP_NONE;
            endcase
        end
        d.valid = (d.op != dec_pkg::OP_NONE);
    end
endmodule

// >>> logic/insn_decode.sv
`timescale 1ns/1ps
module insn_decode (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        word_valid,
    input  wire logic [15:0] word,
    output dec_pkg::op_t     op,
    output logic             op_valid,
    output logic             unknown,
    output logic [3:0]       shift,
    output logic             mode,
    output logic [6:0]       addr,
    output logic [2:0]       reg_sel,
    output logic [15:0]      imm,
    output logic [1:0]       cmp_mode,
    output logic             pc_advance
);
    // ****************************************
    // field extraction
    // ****************************************
    dec_if d ();
    op_table u_table (
        .word (word),
        .d    (d)
    );

    typedef enum logic [1:0] {
        ST_FIRST  = 2'b01,
        ST_SECOND = 2'b10
    } state_t;

    // ****************************************
    // sequencing
    // ****************************************
    state_t       state;
    state_t       next_state;
    dec_pkg::op_t held_op;
    dec_pkg::op_t next_held_op;
    logic [3:0]   held_shift;
    logic [3:0]   next_held_shift;
    logic [2:0]   held_reg;
    logic [2:0]   next_held_reg;
    dec_pkg::op_t next_op;
    logic         next_op_valid;
    logic         next_unknown;
    logic [3:0]   next_shift;
    logic         next_mode;
    logic [6:0]   next_addr;
    logic [2:0]   next_reg_sel;
    logic [15:0]  next_imm;
    logic [1:0]   next_cmp_mode;
    logic         next_pc_advance;

    always_comb begin
        next_state      = state;
        next_held_op    = held_op;
        next_held_shift = held_shift;
        next_held_reg   = held_reg;
        next_op         = op;
        next_op_valid   = 1'b0;
        next_unknown    = 1'b0;
        next_shift      = shift;
        next_mode       = mode;
        next_addr       = addr;
        next_reg_sel    = reg_sel;
        next_imm        = imm;
        next_cmp_mode   = cmp_mode;
        next_pc_advance = 1'b0;
        if (word_valid) begin
            next_pc_advance = 1'b1;
            unique case (state)
                ST_FIRST: begin
                    if (d.two_word) begin
                        // hold first word until operand word arrives
                        next_state      = ST_SECOND;
                        next_held_op    = d.op;
                        next_held_shift = d.shift;
                        next_held_reg   = d.reg_sel;
                    end else begin
                        next_op       = d.op;
                        next_op_valid = d.valid;
                        next_unknown  = !d.valid;
                        next_shift    = d.shift;
                        next_mode     = d.mode;
                        next_addr     = d.addr;
                        next_reg_sel  = d.reg_sel;
                        next_imm      = {7'h00, d.imm};
                        next_cmp_mode = d.cmp_mode;
                    end
                end
                ST_SECOND: begin
                    next_state    = ST_FIRST;
                    next_op       = held_op;
                    next_op_valid = 1'b1;
                    next_shift    = held_shift;
                    next_reg_sel  = held_reg;
                    next_imm      = word;
                    next_mode     = 1'b0;
                    next_addr     = 7'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= ST_FIRST;
            held_op    <= dec_pkg::OP_NONE;
            held_shift <= 4'h0;
            held_reg   <= 3'h0;
            op         <= dec_pkg::OP_NONE;
            op_valid   <= 1'b0;
            unknown    <= 1'b0;
            shift      <= 4'h0;
            mode       <= 1'b0;
            addr       <= 7'h00;
            reg_sel    <= 3'h0;
            imm        <= 16'h0000;
            cmp_mode   <= 2'h0;
            pc_advance <= 1'b0;
        end else begin
            state      <= next_state;
            held_op    <= next_held_op;
            held_shift <= next_held_shift;
            held_reg   <= next_held_reg;
            op         <= next_op;
            op_valid   <= next_op_valid;
            unknown    <= next_unknown;
            shift      <= next_shift;
            mode       <= next_mode;
            addr       <= next_addr;
            reg_sel    <= next_reg_sel;
            imm        <= next_imm;
            cmp_mode   <= next_cmp_mode;
            pc_advance <= next_pc_advance;
        end
    end
endmodule

// >>> sim/insn_decode_assertions.sv
`timescale 1ns/1ps
// ************
// decode checks
// ************
module insn_decode_assertions (
    input logic         clk,
    input logic         rst_n,
    input logic         word_valid,
    input logic [15:0]  word,
    input dec_pkg::op_t op,
    input logic         op_valid,
    input logic         unknown,
    input logic [3:0]   shift,
    input logic         mode,
    input logic [6:0]   addr,
    input logic [2:0]   reg_sel,
    input logic [15:0]  imm,
    input logic [1:0]   cmp_mode,
    input logic         pc_advance
);
    logic second_due;
    logic first;
    logic long_form;
    logic mem_byte;
    assign mem_byte = word[15:8] inside {8'h4f, 8'h44, 8'h45, 8'h46,
        8'h40, 8'h7b, 8'h41, 8'h52, 8'h3d};
    assign first = word_valid && !second_due;
    assign long_form = word[15:12] == dec_pkg::NIB_LONG
        && (word[7:0] == dec_pkg::LOW_SUB_LONG
        || word[7:0] == dec_pkg::LOW_XOR_LONG
        || (!word[11] && word[7:0] == dec_pkg::LOW_AUX_LONG));
    // a second word is operand data, never an opcode
    always_ff @(posedge clk) begin
        if (!rst_n)
            second_due <= 1'b0;
        else if (word_valid)
            second_due <= first && long_form;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sub_mem_fields: assert property (
        first && word[15:12] == 4'h1 |=> op_valid
        && op == dec_pkg::OP_SUB_MEM && shift == $past(word[11:8])
        && mode == $past(word[7]) && addr == $past(word[6:0]))
        else $error("memory subtract fields wrong");
    a_store_shift: assert property (
        first && word[15:11] == 5'h0c |=> op == dec_pkg::OP_STORE_LOW
        && shift == {1'b0, $past(word[10:8])})
        else $error("store shift wrong");
    a_compare_mode: assert property (
        first && word[15:2] == 14'h3394 |=> op == dec_pkg::OP_AUX_CMP
        && cmp_mode == $past(word[1:0]))
        else $error("compare mode wrong");
    a_add_product: assert property (
        first && word == 16'hce15 |=> op_valid
        && op == dec_pkg::OP_ADD_PROD)
        else $error("product add not decoded");
    a_long_first: assert property (
        first && long_form |=> pc_advance && !op_valid && !unknown)
        else $error("first of two words mishandled");
    a_second_operand: assert property (
        word_valid && second_due |=> op_valid && pc_advance
        && imm == $past(word))
        else $error("second word not taken as operand");
    a_aux_short_sel: assert property (
        first && word[15:11] == 5'h18 |=> op == dec_pkg::OP_AUX_LOAD_SHORT
        && reg_sel == $past(word[10:8]) && imm == {8'h00, $past(word[7:0])})
        else $error("aux short load wrong");
    a_page_imm: assert property (
        first && word[15:9] == 7'h64 |=> op == dec_pkg::OP_PAGE_IMM
        && imm == {7'h00, $past(word[8:0])})
        else $error("page immediate wrong");
    a_idle_quiet: assert property (
        !word_valid |=> !op_valid && !pc_advance)
        else $error("pulse without a word");
    a_aux_pointer_sel: assert property (
        first && word[15:8] == 8'h55 && word[6:3] == 4'h1 |=>
        op == dec_pkg::OP_AUX_PTR && reg_sel == $past(word[2:0]))
        else $error("aux pointer value wrong");
    a_short_imm_value: assert property (
        first && (word[15:8] == 8'hcd || word[15:8] == 8'h7e
        || word[15:8] == 8'h7f) |=> op_valid
        && imm == {8'h00, $past(word[7:0])})
        else $error("short immediate wrong");
    a_mem_byte_fields: assert property (
        first && mem_byte |=> op_valid && mode == $past(word[7])
        && addr == $past(word[6:0]))
        else $error("memory operand fields wrong");
endmodule
bind insn_decode insn_decode_assertions chk_i (.clk, .rst_n, .word_valid,
    .word, .op, .op_valid, .unknown, .shift, .mode, .addr, .reg_sel, .imm,
    .cmp_mode, .pc_advance);

// >>> sim/fetch_model.sv
`timescale 1ns/1ps
// ************
// program fetch
// ************
module fetch_model (
    input  logic        clk,
    input  logic        rst_n,
    input  logic        load,
    input  logic [15:0] load_word,
    output logic        word_valid,
    output logic [15:0] word
);
    // idle bus flips each cycle so a stale word never looks steady
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_valid <= 1'b0;
            word       <= 16'h0000;
        end else begin
            word_valid <= load;
            word       <= load ? load_word : ~word;
        end
    end
endmodule

// >>> sim/dsp_subtract_aux_treg_decode_tb.sv
`timescale 1ns/1ps
module dsp_subtract_aux_treg_decode_tb;
    typedef struct packed {
        logic [15:0]  w;
        dec_pkg::op_t op;
    } one_t;
    localparam one_t ONE [19] = '{
        '{16'h1a85, dec_pkg::OP_SUB_MEM},
        '{16'h4f12, dec_pkg::OP_SUB_BORROW},
        '{16'h4493, dec_pkg::OP_SUB_HIGH},
        '{16'hcdff, dec_pkg::OP_SUB_SHORT},
        '{16'h4501, dec_pkg::OP_SUB_LOW_NSX},
        '{16'h467f, dec_pkg::OP_SUB_TREG},
        '{16'h40aa, dec_pkg::OP_CLR_LOAD_HIGH},
        '{16'h7b55, dec_pkg::OP_CLR_LOAD_HIGH_RND},
        '{16'h4180, dec_pkg::OP_CLR_LOAD_LOW_NSX},
        '{16'h6733, dec_pkg::OP_STORE_LOW},
        '{16'h7e10, dec_pkg::OP_AUX_ADD},
        '{16'hce53, dec_pkg::OP_AUX_CMP},
        '{16'hc5a7, dec_pkg::OP_AUX_LOAD_SHORT},
        '{16'h558d, dec_pkg::OP_AUX_PTR},
        '{16'h52c4, dec_pkg::OP_PAGE_MEM},
        '{16'hc9ff, dec_pkg::OP_PAGE_IMM},
        '{16'h7f01, dec_pkg::OP_AUX_SUB},
        '{16'hce15, dec_pkg::OP_ADD_PROD},
        '{16'h3d7e, dec_pkg::OP_TREG_ACC_PROD}};
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         load = 1'b0;
    logic [15:0]  load_word = 16'h0000;
    logic         word_valid;
    logic [15:0]  word;
    dec_pkg::op_t op;
    logic         op_valid, unknown, mode, pc_advance;
    logic [3:0]   shift;
    logic [6:0]   addr;
    logic [2:0]   reg_sel;
    logic [15:0]  imm;
    logic [1:0]   cmp_mode;
    int           mismatches = 0;
    int           check_count = 0;
    always #2.5 clk = ~clk;
    fetch_model fetch (.clk, .rst_n, .load, .load_word, .word_valid, .word);
    insn_decode dut (.clk, .rst_n, .word_valid, .word, .op, .op_valid,
        .unknown, .shift, .mode, .addr, .reg_sel, .imm, .cmp_mode,
        .pc_advance);
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // returns just after the edge that takes the word
    task automatic step(input logic [15:0] w);
        @(posedge clk);
        load      <= 1'b1;
        load_word <= w;
        @(posedge clk);
        load <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_one_word;
        logic hit;
        for (int i = 0; i < 19; i++) begin
            step(ONE[i].w);
            hit = op_valid && pc_advance && !unknown && op === ONE[i].op;
            chk(hit, "one-word op");
        end
    endtask
    task automatic t_two_word;
        logic [15:0]  w [3] = '{16'hd503, 16'hdf06, 16'hd700};
        dec_pkg::op_t e [3];
        logic         hit;
        e = '{dec_pkg::OP_SUB_LONG, dec_pkg::OP_XOR_LONG,
              dec_pkg::OP_AUX_LOAD_LONG};
        for (int i = 0; i < 3; i++) begin
            step(w[i]);
            chk(pc_advance && !op_valid && !unknown, "first word");
            step(16'hce15);
            hit = op_valid && op === e[i] && imm === 16'hce15 && !mode;
            chk(hit, "long op");
            hit = i < 2 ? shift === w[i][11:8] : reg_sel === 3'h7;
            chk(hit, "field");
        end
    endtask
    // reset while the operand word is still owed
    task automatic t_reset_mid;
        step(16'hd503);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(!op_valid && !pc_advance && !unknown && imm === 16'h0000,
            "mid reset");
        step(16'hce15);
        chk(op_valid && op === dec_pkg::OP_ADD_PROD, "after reset");
    endtask
    task automatic t_unknown;
        step(16'h0000);
        chk(unknown && op_valid === 1'b0, "add word accepted");
        step(16'hd002);
        chk(unknown && op_valid === 1'b0, "long add accepted");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(op_valid === 1'b0 && imm === 16'h0000, "reset state");
        t_one_word();
        t_two_word();
        t_unknown();
        t_reset_mid();
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
